/* File: hw/isrf_edge_det.sv */
// Pin synchroniser and edge detector for external and port pins.
module isrf_edge_det import isrf_pkg::*; (
  input wire logic sys_clk,
  input wire logic arst_n,
  input wire logic [NUM_PINS-1:0] pins_raw,
  isrf_pin_if.det edges
);

  // ----------------------------------------------------------------
  // State: two synchroniser stages and one history stage.
  // ----------------------------------------------------------------
  typedef struct packed {
    logic [NUM_PINS-1:0] meta;
    logic [NUM_PINS-1:0] sync;
    logic [NUM_PINS-1:0] hist;
  } isrf_edge_state_type;

  isrf_edge_state_type state_q; // Registered state.
  isrf_edge_state_type state_d; // Next state.

  // The first stage feeds only the second, keeping metastability contained.
  always_comb begin
    state_d = state_q;
    state_d.meta = pins_raw;
    state_d.sync = state_q.meta;
    state_d.hist = state_q.sync;
  end

  // Pins idle low after reset, so a pin held high gives one rising pulse.
  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      state_q <= '0;
    end else begin
      state_q <= state_d;
    end
  end

  // ----------------------------------------------------------------
  // Per-pin edge pulses.
  // ----------------------------------------------------------------
  for (genvar i = 0; i < NUM_PINS; i++) begin : g_pin
    assign edges.rise[i] = state_q.sync[i] & ~state_q.hist[i];
    assign edges.fall[i] = ~state_q.sync[i] & state_q.hist[i];
  end

endmodule

/* File: hw/isrf_top.sv */
// Interrupt sources, priority routing, context capture and reset flags.
module isrf_top import isrf_pkg::*; (
  input wire logic sys_clk,
  input wire logic arst_n,
  input wire logic [4:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  input wire logic [3:0] avs_byteenable,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest,
  input wire logic [2:0] ext_irq_pin,
  input wire logic [3:0] second_port_pins,
  input wire logic timer_tick,
  input wire logic irq_ack,
  input wire logic irq_ack_high,
  input wire logic [PC_WIDTH-1:0] return_pc,
  input wire logic [7:0] working_register,
  input wire logic [7:0] status_register,
  input wire logic [3:0] bank_select_register,
  input wire logic reset_instr_evt,
  input wire logic watchdog_evt,
  input wire logic sleep_evt,
  input wire logic clear_wdt_evt,
  output logic irq_high_req,
  output logic irq_low_req,
  output logic wake_req,
  output logic stack_push,
  output logic [PC_WIDTH-1:0] stack_pc,
  output logic [7:0] shadow_working_register,
  output logic [7:0] shadow_status,
  output logic [3:0] shadow_bsr,
  output logic soft_brownout_enable
);

  // ----------------------------------------------------------------
  // State of the whole controller.
  // ----------------------------------------------------------------
  typedef struct packed {
    logic [7:0] ctrl_main;   // Global enables, main enables and flags.
    logic [7:0] ctrl_second; // Edge selects and priorities.
    logic [7:0] ctrl_third;  // External one/two priorities, enables, flags.
    logic [7:0] reset_cause; // Priority enable and reset cause flags.
    logic [7:0] timer_cfg;   // Timer run and width select.
    logic [15:0] timer_count; // High:low counter pair.
    logic [31:0] rdata;      // Read data held for the bus.
    logic waitreq;           // Bus wait request.
    logic irq_high;          // High priority request to the core.
    logic irq_low;           // Low priority request to the core.
    logic wake;              // Wake request for idle or sleep.
    logic push;              // Return stack push strobe.
    logic [PC_WIDTH-1:0] pc; // Address pushed on the return stack.
    logic [7:0] sh_w;        // Fast return copy of the working register.
    logic [7:0] sh_s;        // Fast return copy of the status register.
    logic [3:0] sh_b;        // Fast return copy of the bank select.
  } isrf_state_type;

  isrf_state_type state_q; // Registered state.
  isrf_state_type state_d; // Next state.

  // ----------------------------------------------------------------
  // Pin synchroniser and edge detector.
  // ----------------------------------------------------------------
  isrf_pin_if pin_bus ();

  isrf_edge_det u_edge (
    .sys_clk(sys_clk),
    .arst_n(arst_n),
    .pins_raw({second_port_pins, ext_irq_pin}),
    .edges(pin_bus.det)
  );

  // ----------------------------------------------------------------
  // Source events.
  // ----------------------------------------------------------------
  logic [2:0] ext_edge_select; // Per external pin, 1 selects rising.
  logic [2:0] ext_hit;         // Valid edge seen on an external pin.
  logic port_hit;              // Any change on port pins 7:4.

  assign ext_edge_select = {state_q.ctrl_second[SC_EDGE2],
                            state_q.ctrl_second[SC_EDGE1],
                            state_q.ctrl_second[SC_EDGE0]};

  // Each external pin looks only at its selected edge.
  always_comb begin
    for (int i = 0; i < 3; i++) begin
      ext_hit[i] = ext_edge_select[i] ? pin_bus.rise[i] : pin_bus.fall[i]; // see R4
    end
  end

  // Either direction of change on the upper port pins counts.
  assign port_hit = |(pin_bus.rise[NUM_PINS-1:PIN_PORT_LO] | pin_bus.fall[NUM_PINS-1:PIN_PORT_LO]); // see R16

  // ----------------------------------------------------------------
  // Source vectors: timer, external zero, port change, ext one, ext two.
  // ----------------------------------------------------------------
  logic [4:0] src_flag;  // Pending flags.
  logic [4:0] src_en;    // Enables.
  logic [4:0] src_prio;  // 1 is high priority.
  logic [4:0] src_act;   // Flag and enable both set.
  logic any_high;        // An active high priority source.
  logic any_low;         // An active low priority source.
  logic prio_on;         // Two priority levels in use.

  assign src_flag = {state_q.ctrl_third[TH_X2_FLAG], state_q.ctrl_third[TH_X1_FLAG],
                     state_q.ctrl_main[MN_PC_FLAG], state_q.ctrl_main[MN_X0_FLAG],
                     state_q.ctrl_main[MN_TMR_FLAG]};
  assign src_en = {state_q.ctrl_third[TH_X2_EN], state_q.ctrl_third[TH_X1_EN],
                   state_q.ctrl_main[MN_PC_EN], state_q.ctrl_main[MN_X0_EN],
                   state_q.ctrl_main[MN_TMR_EN]}; // see R14 see R17
  // External zero has no priority bit and is tied high.
  assign src_prio = {state_q.ctrl_third[TH_X2_PRIO], state_q.ctrl_third[TH_X1_PRIO],
                     state_q.ctrl_second[SC_PC_PRIO], 1'b1,
                     state_q.ctrl_second[SC_TMR_PRIO]}; // see R10 see R11 see R15 see R17
  assign src_act = src_flag & src_en; // see R6
  assign any_high = |(src_act & src_prio);
  assign any_low = |(src_act & ~src_prio);
  assign prio_on = state_q.reset_cause[RC_PRIO_EN];

  // ----------------------------------------------------------------
  // Bus request decode.
  // ----------------------------------------------------------------
  logic bus_req;  // A read or a write is presented.
  logic wr_now;   // The write completes at this edge.
  logic [7:0] wb; // Write data byte lane 0.

  assign bus_req = avs_read | avs_write;
  // Writes land on the edge at which the master sees wait request low.
  assign wr_now = avs_write & ~state_q.waitreq;
  assign wb = avs_writedata[7:0];

  // ----------------------------------------------------------------
  // Next-state logic.
  // ----------------------------------------------------------------
  always_comb begin
    logic [15:0] cnt_next; // Counter after this tick.
    logic rollover;        // Counter wrapped at this tick.
    cnt_next = state_q.timer_count;
    rollover = 1'b0;
    state_d = state_q;
    state_d.push = 1'b0;

    // Timer counting; the width select picks which wrap is an overflow.
    if (timer_tick && state_q.timer_cfg[TC_RUN]) begin
      if (state_q.timer_cfg[TC_EIGHT_BIT]) begin
        cnt_next[7:0] = state_q.timer_count[7:0] + 8'h01;
        rollover = (state_q.timer_count[7:0] == 8'hff); // see R12
      end else begin
        cnt_next = state_q.timer_count + 16'h0001;
        rollover = (state_q.timer_count == 16'hffff); // see R13
      end
    end
    state_d.timer_count = cnt_next;

    // Wait request: one low cycle answers each request.
    state_d.waitreq = ~(bus_req & state_q.waitreq);

    // Read data is captured when the request is first seen.
    if (avs_read && state_q.waitreq) begin
      if (avs_address == ADDR_CTRL_MAIN) begin
        state_d.rdata = {24'h000000, state_q.ctrl_main};
      end else if (avs_address == ADDR_CTRL_SECOND) begin
        state_d.rdata = {24'h000000, state_q.ctrl_second};
      end else if (avs_address == ADDR_CTRL_THIRD) begin
        state_d.rdata = {24'h000000, state_q.ctrl_third};
      end else if (avs_address == ADDR_RESET_CAUSE) begin
        // The unimplemented bit is never stored, so it reads as zero.
        state_d.rdata = {24'h000000, state_q.reset_cause}; // see R2 see R3
      end else if (avs_address == ADDR_TIMER_COUNT) begin
        state_d.rdata = {16'h0000, state_q.timer_count};
      end else if (avs_address == ADDR_TIMER_CFG) begin
        state_d.rdata = {24'h000000, state_q.timer_cfg};
      end else begin
        // Unmapped addresses read as zero.
        state_d.rdata = 32'h00000000;
      end
    end

    // Register writes; unmapped writes are dropped.
    if (wr_now && avs_byteenable[0]) begin
      if (avs_address == ADDR_CTRL_MAIN) begin
        // Flags are writable so software can clear them in its handler.
        state_d.ctrl_main = wb; // see R7
      end else if (avs_address == ADDR_CTRL_SECOND) begin
        state_d.ctrl_second = wb & WM_CTRL_SECOND;
      end else if (avs_address == ADDR_CTRL_THIRD) begin
        state_d.ctrl_third = wb & WM_CTRL_THIRD;
      end else if (avs_address == ADDR_RESET_CAUSE) begin
        // Watchdog and powerdown flags are read-only here.
        state_d.reset_cause = (state_q.reset_cause & ~WM_RESET_CAUSE) | (wb & WM_RESET_CAUSE); // see R1 see R3
      end else if (avs_address == ADDR_TIMER_CFG) begin
        state_d.timer_cfg = wb & WM_TIMER_CFG;
      end else if (avs_address == ADDR_TIMER_COUNT) begin
        // A write to the count overrides the tick in the same cycle.
        state_d.timer_count[7:0] = wb;
      end
    end
    if (wr_now && avs_byteenable[1] && avs_address == ADDR_TIMER_COUNT) begin
      state_d.timer_count[15:8] = avs_writedata[15:8];
    end

    // Hardware sets after the software write, so a set never gets lost.
    if (rollover) begin
      state_d.ctrl_main[MN_TMR_FLAG] = 1'b1; // see R12 see R13
    end
    if (ext_hit[0]) begin
      state_d.ctrl_main[MN_X0_FLAG] = 1'b1; // see R5
    end
    if (ext_hit[1]) begin
      state_d.ctrl_third[TH_X1_FLAG] = 1'b1; // see R5
    end
    if (ext_hit[2]) begin
      state_d.ctrl_third[TH_X2_FLAG] = 1'b1; // see R5
    end
    if (port_hit) begin
      state_d.ctrl_main[MN_PC_FLAG] = 1'b1; // see R16
    end

    // Reset cause events from the core also win over a write.
    if (reset_instr_evt) begin
      state_d.reset_cause[RC_RESET_INSTR] = 1'b0; // see R2
    end
    if (clear_wdt_evt) begin
      state_d.reset_cause[RC_WDT_TIMEOUT] = 1'b1; // see R2
      state_d.reset_cause[RC_POWERDOWN] = 1'b1;
    end
    if (sleep_evt) begin
      state_d.reset_cause[RC_WDT_TIMEOUT] = 1'b1; // see R2
      state_d.reset_cause[RC_POWERDOWN] = 1'b0;
    end
    if (watchdog_evt) begin
      state_d.reset_cause[RC_WDT_TIMEOUT] = 1'b0; // see R2
    end

    // Taking an interrupt: push the return address, fill the shadow,
    // and close the level that was taken so it cannot re-enter.
    if (irq_ack) begin
      state_d.push = 1'b1;
      state_d.pc = return_pc; // see R18
      state_d.sh_w = working_register; // see R19
      state_d.sh_s = status_register;
      state_d.sh_b = bank_select_register;
      if (prio_on && !irq_ack_high) begin
        state_d.ctrl_main[MN_LOW_EN] = 1'b0;
      end else begin
        state_d.ctrl_main[MN_GLOBAL_EN] = 1'b0;
      end
    end

    // Wake does not look at the global enable; the core decides later
    // whether to vector or to carry on after the sleep instruction.
    state_d.wake = |src_act; // see R8

    // Request routing.
    if (prio_on) begin
      // Low requests wait while any high source is active.
      state_d.irq_high = state_q.ctrl_main[MN_GLOBAL_EN] & any_high; // see R1 see R21
      state_d.irq_low = state_q.ctrl_main[MN_GLOBAL_EN] & state_q.ctrl_main[MN_LOW_EN]
                        & any_low & ~any_high; // see R21
    end else begin
      // Single level: every active source uses the one vector.
      state_d.irq_high = state_q.ctrl_main[MN_GLOBAL_EN] & (|src_act); // see R1 see R9 see R21
      state_d.irq_low = 1'b0;
    end
    // Drop the request in the cycle the core takes it.
    if (irq_ack) begin
      state_d.irq_high = 1'b0;
      state_d.irq_low = 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // State register.
  // ----------------------------------------------------------------
  // Every reset restores the documented reset values.
  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      state_q <= '0;
      state_q.ctrl_main <= RST_CTRL_MAIN;
      state_q.ctrl_second <= RST_CTRL_SECOND;
      state_q.ctrl_third <= RST_CTRL_THIRD;
      state_q.reset_cause <= RST_RESET_CAUSE;
      state_q.timer_cfg <= RST_TIMER_CFG;
      state_q.waitreq <= 1'b1;
    end else begin
      state_q <= state_d;
    end
  end

  // ----------------------------------------------------------------
  // Outputs, all straight from the state register.
  // ----------------------------------------------------------------
  assign avs_readdata = state_q.rdata;
  assign avs_waitrequest = state_q.waitreq;
  assign irq_high_req = state_q.irq_high;
  assign irq_low_req = state_q.irq_low;
  assign wake_req = state_q.wake;
  assign stack_push = state_q.push;
  assign stack_pc = state_q.pc;
  assign shadow_working_register = state_q.sh_w;
  assign shadow_status = state_q.sh_s;
  assign shadow_bsr = state_q.sh_b;
  assign soft_brownout_enable = state_q.reset_cause[RC_SOFT_BROWN];

endmodule

/* File: inc/isrf_pin_if.sv */
// Edge pulses passed from the pin synchroniser to the controller.
interface isrf_pin_if import isrf_pkg::*;;
  logic [NUM_PINS-1:0] rise; // One-cycle pulse per pin on a rising edge.
  logic [NUM_PINS-1:0] fall; // One-cycle pulse per pin on a falling edge.
  modport det (output rise, output fall);
  modport ctl (input rise, input fall);
endinterface

/* File: inc/isrf_pkg.sv */
// Constants shared by the interrupt source and reset flag block.
// Operation
// R1: Priority enable selects two levels or one.
// R2: Reset cause flags readable by software.
// R3: Reset cause bit 5 always reads zero.
// R4: External pins trigger on selected edge.
// R5: Valid external edge sets its flag.
// R6: Cleared enable suppresses external request.
// R7: Software clears external flags itself.
// R8: Enabled pending source wakes idle or sleep.
// R9: After wake, vector taken when globally enabled.
// R10: External one/two priority from third register.
// R11: External zero is always high priority.
// R12: 8-bit timer rollover sets overflow flag.
// R13: 16-bit timer rollover sets overflow flag.
// R14: Timer interrupt gated by main bit 5.
// R15: Timer priority from second register bit 2.
// R16: Port pins 7:4 change sets flag.
// R17: Port change enable bit 3, priority bit 0.
// R18: Taken interrupt pushes return address.
// R19: Taken interrupt copies working/status/bank shadow.
// R20: Without fast return, software saves context.
// R21: Request needs flag, enable, global enable, priority.
package isrf_pkg;

  // ----------------------------------------------------------------
  // Register byte offsets on the Avalon-MM slave.
  // ----------------------------------------------------------------
  localparam logic [4:0] ADDR_CTRL_MAIN = 5'h00;
  localparam logic [4:0] ADDR_CTRL_SECOND = 5'h04;
  localparam logic [4:0] ADDR_CTRL_THIRD = 5'h08;
  localparam logic [4:0] ADDR_RESET_CAUSE = 5'h0c;
  localparam logic [4:0] ADDR_TIMER_COUNT = 5'h10;
  localparam logic [4:0] ADDR_TIMER_CFG = 5'h14;

  // ----------------------------------------------------------------
  // Field positions.
  // ----------------------------------------------------------------
  localparam int MN_GLOBAL_EN = 7;
  localparam int MN_LOW_EN = 6;
  localparam int MN_TMR_EN = 5;
  localparam int MN_X0_EN = 4;
  localparam int MN_PC_EN = 3;
  localparam int MN_TMR_FLAG = 2;
  localparam int MN_X0_FLAG = 1;
  localparam int MN_PC_FLAG = 0;
  localparam int SC_EDGE0 = 6;
  localparam int SC_EDGE1 = 5;
  localparam int SC_EDGE2 = 4;
  localparam int SC_TMR_PRIO = 2;
  localparam int SC_PC_PRIO = 0;
  localparam int TH_X2_PRIO = 7;
  localparam int TH_X1_PRIO = 6;
  localparam int TH_X2_EN = 4;
  localparam int TH_X1_EN = 3;
  localparam int TH_X2_FLAG = 1;
  localparam int TH_X1_FLAG = 0;
  localparam int RC_PRIO_EN = 7;
  localparam int RC_SOFT_BROWN = 6;
  localparam int RC_RESET_INSTR = 4;
  localparam int RC_WDT_TIMEOUT = 3;
  localparam int RC_POWERDOWN = 2;
  localparam int RC_POWER_ON = 1;
  localparam int RC_BROWNOUT = 0;
  localparam int TC_RUN = 7;
  localparam int TC_EIGHT_BIT = 6;

  // ----------------------------------------------------------------
  // Reset values and software write masks.
  // ----------------------------------------------------------------
  localparam logic [7:0] RST_CTRL_MAIN = 8'h00;
  localparam logic [7:0] RST_CTRL_SECOND = 8'h75;
  localparam logic [7:0] RST_CTRL_THIRD = 8'hc0;
  localparam logic [7:0] RST_RESET_CAUSE = 8'h5c;
  localparam logic [7:0] RST_TIMER_CFG = 8'h40;
  localparam logic [7:0] WM_CTRL_SECOND = 8'h75;
  localparam logic [7:0] WM_CTRL_THIRD = 8'hdb;
  localparam logic [7:0] WM_RESET_CAUSE = 8'hd3;
  localparam logic [7:0] WM_TIMER_CFG = 8'hc0;

  // ----------------------------------------------------------------
  // Pin layout and widths.
  // ----------------------------------------------------------------
  localparam int NUM_PINS = 7;
  localparam int PIN_PORT_LO = 3;
  localparam int PC_WIDTH = 21;

endpackage

/* File: verif/isrf_core_model.sv */
// Processor core model: takes requests and offers its context.
module isrf_core_model import isrf_pkg::*; #(
  parameter logic [PC_WIDTH-1:0] PC_VAL = 21'h0a5c3
) (
  input logic sys_clk,
  input logic arst_n,
  input logic accept,
  input logic irq_high_req,
  input logic irq_low_req,
  output logic irq_ack,
  output logic irq_ack_high,
  output logic [PC_WIDTH-1:0] return_pc,
  output logic [7:0] working_register,
  output logic [7:0] status_register,
  output logic [3:0] bank_select_register
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [7:0] ctx_q; // Free-running context, so a late capture shows up.
  assign return_pc = PC_VAL;
  assign working_register = ctx_q;
  assign status_register = ~ctx_q;
  assign bank_select_register = ctx_q[7:4];
  // A one-cycle gap after each ack skips the stale request.
  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      ctx_q <= 8'h00;
      irq_ack <= 1'b0;
      irq_ack_high <= 1'b0;
    end else begin
      ctx_q <= ctx_q + 8'h01;
      irq_ack <= accept && !irq_ack && (irq_high_req || irq_low_req);
      irq_ack_high <= irq_high_req;
    end
  end
endmodule

/* File: verif/isrf_monitor.sv */
// Port-level assertions for the interrupt source and reset flag block.
module isrf_monitor import isrf_pkg::*; (
  input logic sys_clk,
  input logic arst_n,
  input logic [4:0] avs_address,
  input logic avs_read,
  input logic [31:0] avs_readdata,
  input logic avs_waitrequest,
  input logic irq_ack,
  input logic [PC_WIDTH-1:0] return_pc,
  input logic [7:0] working_register,
  input logic [7:0] status_register,
  input logic [3:0] bank_select_register,
  input logic irq_high_req,
  input logic irq_low_req,
  input logic wake_req,
  input logic stack_push,
  input logic [PC_WIDTH-1:0] stack_pc,
  input logic [7:0] shadow_working_register,
  input logic [7:0] shadow_status,
  input logic [3:0] shadow_bsr
);
  timeunit 1ns;
  timeprecision 1ns;
  // ----------------------------------------------------------------
  // One clock domain, so clocking and reset are given once.
  // ----------------------------------------------------------------
  default clocking mon_cb @(posedge sys_clk); endclocking
  default disable iff (!arst_n);
  AST_WAIT_ONE: assert property (!avs_waitrequest |=> avs_waitrequest)
    else $error("waitrequest low too long");
  AST_BIT5_ZERO: assert property (!avs_waitrequest && $past(avs_read) &&
    $past(avs_address) == ADDR_RESET_CAUSE |-> avs_readdata[5] == 1'b0) else $error("reset cause bit 5 set");
  AST_PUSH: assert property (irq_ack |=> stack_push)
    else $error("no push after ack");
  AST_PUSH_CAUSE: assert property (stack_push |-> $past(irq_ack))
    else $error("push without ack");
  AST_PC: assert property (irq_ack |=> stack_pc == $past(return_pc))
    else $error("pc not captured");
  AST_SHADOW: assert property (irq_ack |=> shadow_working_register == $past(working_register) &&
    shadow_status == $past(status_register) && shadow_bsr == $past(bank_select_register)) else $error("shadow wrong");
  AST_REQ_DROP: assert property (irq_ack |=> !irq_high_req && !irq_low_req)
    else $error("request after ack");
  AST_LOW_EXCL: assert property (irq_low_req |-> !irq_high_req)
    else $error("low and high together");
  AST_WAKE: assert property (irq_high_req || irq_low_req |-> wake_req)
    else $error("request without wake");
  // Main scenarios that the bench should reach.
  cover property (irq_low_req);
  cover property (stack_push ##1 !stack_push);
  cover property (wake_req && !irq_high_req);
endmodule
bind isrf_top isrf_monitor isrf_monitor_inst (.*);

/* File: verif/tb_top.sv */
// Self-checking bench for the interrupt source and reset flag block.
module tb_top import isrf_pkg::*; ;
  timeunit 1ns;
  timeprecision 1ns;
  // ----------------------------------------------------------------
  // Signals, design and core model.
  // ----------------------------------------------------------------
  logic sys_clk, arst_n, avs_read, avs_write, avs_waitrequest, timer_tick, irq_ack, irq_ack_high, accept;
  logic reset_instr_evt, watchdog_evt, sleep_evt, clear_wdt_evt, soft_brownout_enable;
  logic irq_high_req, irq_low_req, wake_req, stack_push;
  logic [4:0] avs_address;
  logic [31:0] avs_writedata, avs_readdata, rd;
  logic [3:0] avs_byteenable, second_port_pins, bank_select_register, shadow_bsr;
  logic [2:0] ext_irq_pin;
  logic [PC_WIDTH-1:0] return_pc, stack_pc;
  logic [7:0] working_register, status_register, shadow_working_register, shadow_status;
  int failures = 0;
  int n_compared = 0;
  int cycles = 0;
  localparam logic [PC_WIDTH-1:0] PC_VAL = 21'h0a5c3;
  localparam logic [4:0] MN = ADDR_CTRL_MAIN, RC = ADDR_RESET_CAUSE, SC = ADDR_CTRL_SECOND, TH = ADDR_CTRL_THIRD;
  localparam logic [4:0] TC = ADDR_TIMER_CFG, TN = ADDR_TIMER_COUNT;
  initial begin
    sys_clk = 1'b0;
    forever #50 sys_clk = ~sys_clk;
  end
  isrf_top isrf_top_inst (.*);
  isrf_core_model #(.PC_VAL(PC_VAL)) isrf_core_model_inst (.*);
  // ----------------------------------------------------------------
  // Shared tasks.
  // ----------------------------------------------------------------
  task chk(input logic [31:0] got, exp);
    n_compared++;
    if (got !== exp) begin
      failures++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task chk2(input logic [1:0] got, exp);
    chk({30'h0, got}, {30'h0, exp});
  endtask
  task cyc(input int n);
    repeat (n) @(posedge sys_clk);
  endtask
  // One-cycle pulses: tick, instr, watchdog, sleep, clear.
  task pulse(input logic [4:0] e);
    @(posedge sys_clk) {timer_tick, reset_instr_evt, watchdog_evt, sleep_evt, clear_wdt_evt} <= e;
    @(posedge sys_clk) {timer_tick, reset_instr_evt, watchdog_evt, sleep_evt, clear_wdt_evt} <= 5'h00;
  endtask
  // Holds the request until waitrequest is sampled low.
  task bus(input logic w, logic [4:0] a, logic [15:0] d);
    @(posedge sys_clk);
    {avs_address, avs_write, avs_read, avs_writedata} <= {a, w, !w, 16'h0000, d};
    @(posedge sys_clk);
    while (avs_waitrequest !== 1'b0) @(posedge sys_clk);
    rd = avs_readdata;
    {avs_read, avs_write} <= 2'h0;
  endtask
  task wr(input logic [4:0] a, logic [15:0] d);
    bus(1'b1, a, d);
  endtask
  task rchk(input logic [4:0] a, logic [15:0] e);
    bus(1'b0, a, 16'h0);
    chk(rd, {16'h0, e});
  endtask
  task reqs(input int n, logic [1:0] e);
    cyc(n);
    chk2({irq_high_req, irq_low_req}, e);
  endtask
  task wait_push;
    for (int k = 0; k < 20 && stack_push !== 1'b1; k++) @(posedge sys_clk);
    chk2({1'b0, stack_push}, 2'h1);
    chk({11'h0, stack_pc}, {11'h0, PC_VAL});
  endtask
  task wrap_up;
    $display("compared %0d, failures %0d", n_compared, failures);
    if (failures == 0 && n_compared > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask
  // ----------------------------------------------------------------
  // Scenarios.
  // ----------------------------------------------------------------
  task t_reg_reset;
    rchk(MN, 16'h0);
    rchk(SC, 16'h75);
    rchk(TH, 16'hc0);
    rchk(RC, 16'h5c);
    rchk(TC, 16'h40);
    rchk(5'h18, 16'h0);
  endtask
  // Read-only flags hold; core events set and clear them.
  task t_reset_cause;
    wr(RC, 16'hff);
    rchk(RC, 16'hdf);
    chk2({1'b0, soft_brownout_enable}, 2'h1);
    wr(RC, 16'h0);
    rchk(RC, 16'h0c);
    pulse(5'h02);
    rchk(RC, 16'h08);
    pulse(5'h01);
    wr(RC, 16'h10);
    pulse(5'h08);
    rchk(RC, 16'h0c);
    pulse(5'h04);
    rchk(RC, 16'h04);
  endtask
  // Each pin, each polarity: the wrong edge must leave the flag clear.
  task t_ext_edges;
    logic [4:0] fa;
    int fb;
    for (int i = 0; i < 3; i++) begin
      fa = (i == 0) ? MN : TH;
      fb = (i == 0) ? 1 : i - 1;
      for (int p = 0; p < 2; p++) begin
        wr(SC, (p == 1) ? 16'h70 : 16'h0);
        ext_irq_pin[i] <= ~p[0];
        cyc(6);
        wr(fa, 16'h0);
        ext_irq_pin[i] <= p[0];
        cyc(6);
        bus(1'b0, fa, 16'h0);
        chk2({1'b0, rd[fb]}, 2'h1);
        wr(fa, 16'h0);
        ext_irq_pin[i] <= ~p[0];
        cyc(6);
        bus(1'b0, fa, 16'h0);
        chk2({1'b0, rd[fb]}, 2'h0);
      end
    end
  endtask
  task t_requests;
    wr(SC, 16'h40);
    wr(MN, 16'h10);
    ext_irq_pin[0] <= 1'b1;
    cyc(6);
    chk2({wake_req, irq_high_req}, 2'h2);
    accept <= 1'b1;
    wr(MN, 16'h92);
    wait_push();
    rchk(MN, 16'h12);
    accept <= 1'b0;
    wr(MN, 16'h82);
    cyc(3);
    chk2({irq_high_req, wake_req}, 2'h0);
    wr(RC, 16'h80);
    wr(MN, 16'hd2);
    reqs(3, 2'h2);
    wr(SC, 16'h60);
    wr(MN, 16'hc0);
    ext_irq_pin[0] <= 1'b0;
    wr(TH, 16'h08);
    ext_irq_pin[1] <= 1'b1;
    reqs(6, 2'h1);
    wr(TH, 16'h49);
    reqs(3, 2'h2);
    wr(TH, 16'h09);
    wr(RC, 16'h0);
    reqs(3, 2'h2);
    accept <= 1'b1;
    wait_push();
    accept <= 1'b0;
    wr(TH, 16'hc0);
    ext_irq_pin[1] <= 1'b0;
  endtask
  task t_timer_port;
    wr(MN, 16'h0);
    wr(TC, 16'hc0);
    wr(TN, 16'h00ff);
    pulse(5'h10);
    rchk(MN, 16'h04);
    wr(MN, 16'h0);
    wr(TC, 16'h80);
    wr(TN, 16'h00ff);
    pulse(5'h10);
    rchk(MN, 16'h0);
    rchk(TN, 16'h0100);
    wr(TN, 16'hffff);
    pulse(5'h10);
    rchk(MN, 16'h04);
    wr(TC, 16'h0);
    wr(RC, 16'h80);
    wr(SC, 16'h0);
    wr(MN, 16'he4);
    reqs(3, 2'h1);
    wr(MN, 16'hc4);
    reqs(3, 2'h0);
    wr(MN, 16'h0);
    second_port_pins <= 4'h8;
    cyc(6);
    rchk(MN, 16'h01);
    wr(SC, 16'h01);
    wr(MN, 16'h89);
    reqs(3, 2'h2);
  endtask
  // ----------------------------------------------------------------
  // Hang guard and main sequence.
  // ----------------------------------------------------------------
  always @(posedge sys_clk) begin
    cycles++;
    if (cycles == 5000) begin
      failures++;
      wrap_up();
    end
  end
  initial begin
    arst_n = 1'b0;
    avs_byteenable = 4'h3;
    {avs_address, avs_read, avs_write, avs_writedata, ext_irq_pin, second_port_pins, timer_tick, accept} = '0;
    {reset_instr_evt, watchdog_evt, sleep_evt, clear_wdt_evt} = 4'h0;
    repeat (16) @(posedge sys_clk);
    arst_n <= 1'b1;
    t_reg_reset();
    t_reset_cause();
    t_ext_edges();
    t_requests();
    t_timer_port();
    wrap_up();
  end
endmodule
